// ---- logic/brw_burst.sv ----
/*
  Burst read wrap engine with its configuration register.
  Assumes the host drives burst clock, chip select and address strobe
  synchronously to the burst clock, and the array answers combinationally.
*/
`timescale 1ns/10ps
module brw_burst (
  input  wire logic                         clock_in,
  input  wire logic                         reset_in,
  input  wire logic                         cfg_write_in,
  input  wire logic [15:0]                  cfg_wdata_in,
  input  wire logic                         cmd_reset_in,
  output logic      [15:0]                  cfg_rdata_out,
  input  wire logic                         burst_clk_in,
  input  wire logic                         chip_select_n_in,
  input  wire logic                         address_valid_strobe_n_in,
  input  wire logic                         write_enable_n_in,
  input  wire logic [brw_pkg::HI_W-1:0]     addr_hi_in,
  input  wire logic [brw_pkg::DATA_W-1:0]   adq_in,
  output logic      [brw_pkg::DATA_W-1:0]   adq_out,
  output logic                              adq_oe_n_out,
  output logic                              ready_out,
  output logic      [brw_pkg::ADDR_W-1:0]   mem_addr_out,
  input  wire logic [brw_pkg::DATA_W-1:0]   mem_data_in
);
  import brw_pkg::*;

  // ******************************************************************
  // Core domain: configuration register.
  // ******************************************************************
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic        cfg_tgl_ff;
  logic        nxt_cfg_tgl;

  // Command reset is ignored; only the asynchronous reset restores defaults.
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_cfg_tgl = cfg_tgl_ff;
    if (cfg_write_in) begin
      nxt_cfg     = cfg_wdata_in;
      nxt_cfg_tgl = ~cfg_tgl_ff;
    end
  end

  // Registers the configuration word and its update toggle.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_ff     <= CFG_DEFAULT;
      cfg_tgl_ff <= 1'b0;
    end else begin
      cfg_ff     <= nxt_cfg;
      cfg_tgl_ff <= nxt_cfg_tgl;
    end
  end

  assign cfg_rdata_out = cfg_ff;

  // ******************************************************************
  // Link domain: configuration copy taken on a synchronised toggle.
  // ******************************************************************
  logic        tgl_sync;
  logic        tgl_seen_ff;
  logic [15:0] lcfg_ff;
  logic [15:0] nxt_lcfg;

  brw_sync u_tgl_sync (
    .clk_in    (burst_clk_in),
    .reset_in  (reset_in),
    .level_in  (cfg_tgl_ff),
    .level_out (tgl_sync)
  );

  // The word is stable for two burst clocks before the toggle is seen.
  always_comb begin
    nxt_lcfg = lcfg_ff;
    if (tgl_sync != tgl_seen_ff) begin
      nxt_lcfg = cfg_ff;
    end
  end

  // Registers the link copy of the configuration.
  always_ff @(posedge burst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lcfg_ff     <= CFG_DEFAULT;
      tgl_seen_ff <= 1'b0;
    end else begin
      lcfg_ff     <= nxt_lcfg;
      tgl_seen_ff <= tgl_sync;
    end
  end

  // ******************************************************************
  // Link domain: decoded settings.
  // ******************************************************************
  logic       sync_mode;
  logic [2:0] len_code;
  logic       wrap8;
  logic       wrap16;
  logic [3:0] lat_code;
  logic [3:0] lat_cycles;

  // Reserved length codes fall back to continuous; latency is clamped.
  always_comb begin
    sync_mode = ~lcfg_ff[CFG_READ_MODE_BIT];
    len_code  = lcfg_ff[CFG_LEN_MSB:CFG_LEN_LSB];
    wrap8     = (len_code == LEN_WRAP8);
    wrap16    = (len_code == LEN_WRAP16);
    lat_code  = lcfg_ff[CFG_LAT_MSB:CFG_LAT_LSB];
    if (lat_code < LAT_CODE_MIN) begin
      lat_cycles = LAT_MIN;
    end else if (lat_code > LAT_CODE_MAX) begin
      lat_cycles = LAT_MAX;
    end else begin
      lat_cycles = lat_code + LAT_OFFSET;
    end
  end

  // ******************************************************************
  // Link domain: burst engine.
  // ******************************************************************
  brw_state_t          st_ff;
  brw_state_t          nxt_st;
  logic [ADDR_W-1:0]   addr_ff;
  logic [ADDR_W-1:0]   nxt_addr;
  logic [ADDR_W-1:0]   start_ff;
  logic [ADDR_W-1:0]   nxt_start;
  logic [ADDR_W-1:0]   step_addr;
  logic [3:0]          cnt_ff;
  logic [3:0]          nxt_cnt;
  logic [4:0]          words_ff;
  logic [4:0]          nxt_words;
  logic                crossed_ff;
  logic                nxt_crossed;
  logic                valid_ff;
  logic                nxt_valid;
  logic [DATA_W-1:0]   data_ff;
  logic [DATA_W-1:0]   nxt_data;
  logic                oe_n_ff;
  logic                nxt_oe_n;
  logic                capture;
  logic [3:0]          half_ws;
  logic [3:0]          eff_wait;
  logic                at_limit;

  // Next address: wrap modes change only the in-group offset.
  always_comb begin
    if (wrap8) begin
      step_addr = {addr_ff[ADDR_W-1:3], 3'(addr_ff[2:0] + 3'h1)};
    end else if (wrap16) begin
      step_addr = {addr_ff[ADDR_W-1:4], 4'(addr_ff[3:0] + 4'h1)};
    end else begin
      step_addr = ADDR_W'(addr_ff + 24'h000001);
    end
  end

  // Extra waits at the first half crossing grow with the start offset.
  always_comb begin
    eff_wait = (lat_cycles > HALF_WS_BASE) ? HALF_WS_BASE : lat_cycles;
    if (4'({1'b0, start_ff[2:0]}) + eff_wait > HALF_WS_BASE) begin
      half_ws = 4'({1'b0, start_ff[2:0]} + eff_wait - HALF_WS_BASE);
    end else begin
      half_ws = 4'h0;
    end
    at_limit = (wrap8 && words_ff == WORDS_WRAP8) ||
               (wrap16 && words_ff == WORDS_WRAP16);
  end

  // Writes never start a burst, they keep asynchronous timing.
  assign capture = ~chip_select_n_in & ~address_valid_strobe_n_in
                   & write_enable_n_in & sync_mode;

  // Next state of the engine.
  always_comb begin
    nxt_st      = st_ff;
    nxt_addr    = addr_ff;
    nxt_start   = start_ff;
    nxt_cnt     = cnt_ff;
    nxt_words   = words_ff;
    nxt_crossed = crossed_ff;
    nxt_valid   = 1'b0;
    nxt_data    = data_ff;
    nxt_oe_n    = oe_n_ff;
    if (chip_select_n_in || !write_enable_n_in) begin
      nxt_st   = ST_IDLE;
      nxt_oe_n = 1'b1;
    end else if (!address_valid_strobe_n_in) begin
      nxt_oe_n = 1'b1;
      if (capture) begin
        nxt_st      = ST_WAIT;
        nxt_addr    = {addr_hi_in, adq_in};
        nxt_start   = {addr_hi_in, adq_in};
        nxt_cnt     = lat_cycles;
        nxt_words   = 5'h00;
        nxt_crossed = 1'b0;
      end else begin
        nxt_st = ST_IDLE;
      end
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          nxt_st = ST_IDLE;
        end
        ST_WAIT, ST_STALL: begin
          nxt_cnt = 4'(cnt_ff - 4'h1);
          if (cnt_ff == 4'h1) begin
            nxt_st      = ST_BURST;
            nxt_data    = mem_data_in;
            nxt_addr    = step_addr;
            nxt_words   = 5'(words_ff + 5'h01);
            nxt_valid   = 1'b1;
            nxt_oe_n    = 1'b0;
            nxt_crossed = crossed_ff | (st_ff == ST_STALL);
          end
        end
        ST_BURST: begin
          if (at_limit) begin
            nxt_st = ST_HOLD;
          end else if (wrap16 && !crossed_ff && addr_ff[3] != start_ff[3]) begin
            nxt_crossed = 1'b1;
            if (half_ws != 4'h0) begin
              nxt_st  = ST_STALL;
              nxt_cnt = half_ws;
            end else begin
              nxt_data  = mem_data_in;
              nxt_addr  = step_addr;
              nxt_words = 5'(words_ff + 5'h01);
              nxt_valid = 1'b1;
            end
          end else begin
            nxt_data  = mem_data_in;
            nxt_addr  = step_addr;
            nxt_words = (wrap8 || wrap16) ? 5'(words_ff + 5'h01) : words_ff;
            nxt_valid = 1'b1;
          end
        end
        ST_HOLD: begin
          nxt_st = ST_HOLD;
        end
        default: begin
          nxt_st   = ST_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Registers the engine state.
  always_ff @(posedge burst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_ff      <= ST_IDLE;
      addr_ff    <= '0;
      start_ff   <= '0;
      cnt_ff     <= 4'h0;
      words_ff   <= 5'h00;
      crossed_ff <= 1'b0;
      valid_ff   <= 1'b0;
      data_ff    <= '0;
      oe_n_ff    <= 1'b1;
    end else begin
      st_ff      <= nxt_st;
      addr_ff    <= nxt_addr;
      start_ff   <= nxt_start;
      cnt_ff     <= nxt_cnt;
      words_ff   <= nxt_words;
      crossed_ff <= nxt_crossed;
      valid_ff   <= nxt_valid;
      data_ff    <= nxt_data;
      oe_n_ff    <= nxt_oe_n;
    end
  end

  // ******************************************************************
  // Pin outputs.
  // ******************************************************************
  logic rdy_level;

  // Early ready tracks next cycle's valid; polarity applied last.
  always_comb begin
    rdy_level = lcfg_ff[CFG_RDY_EARLY_BIT] ? nxt_valid : valid_ff;
    ready_out = lcfg_ff[CFG_RDY_POL_BIT] ? rdy_level : ~rdy_level;
  end

  assign adq_out      = data_ff;
  assign adq_oe_n_out = oe_n_ff;
  assign mem_addr_out = addr_ff;

  // ******************************************************************
  // Checks.
  // ******************************************************************
  logic [4:0] since_cap_ff;
  logic [4:0] nxt_since_cap;

  // Counts burst clocks since the last address capture, saturating.
  always_comb begin
    nxt_since_cap = since_cap_ff;
    if (capture) begin
      nxt_since_cap = 5'h00;
    end else if (since_cap_ff != 5'h1f) begin
      nxt_since_cap = 5'(since_cap_ff + 5'h01);
    end
  end

  // Registers the capture distance counter.
  always_ff @(posedge burst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      since_cap_ff <= 5'h00;
    end else begin
      since_cap_ff <= nxt_since_cap;
    end
  end

  property p_wrap_group;
    @(posedge burst_clk_in) disable iff (reset_in)
    valid_ff && wrap8 |-> addr_ff[ADDR_W-1:3] == start_ff[ADDR_W-1:3];
  endproperty
  a_wrap_group: assert property (p_wrap_group) else $error("wrap left group");

  property p_wrap_step;
    @(posedge burst_clk_in) disable iff (reset_in)
    valid_ff && $past(valid_ff) && wrap8 && $stable(lcfg_ff)
      |-> addr_ff[2:0] == 3'($past(addr_ff[2:0]) + 3'h1);
  endproperty
  a_wrap_step: assert property (p_wrap_step) else $error("wrap step wrong");

  property p_no_gap8;
    @(posedge burst_clk_in) disable iff (reset_in)
    $rose(valid_ff) && wrap8 && start_ff[2:0] == 3'h0
      |-> (valid_ff || chip_select_n_in || !address_valid_strobe_n_in)[*8];
  endproperty
  a_no_gap8: assert property (p_no_gap8) else $error("gap in 8-word burst");

  property p_hold_last;
    @(posedge burst_clk_in) disable iff (reset_in)
    st_ff == ST_HOLD ##1 st_ff == ST_HOLD |-> $stable(data_ff) && !adq_oe_n_out;
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("last word lost");

  property p_no_128;
    @(posedge burst_clk_in) disable iff (reset_in)
    valid_ff && (wrap8 || wrap16) |-> addr_ff[ADDR_W-1:7] == start_ff[ADDR_W-1:7];
  endproperty
  a_no_128: assert property (p_no_128) else $error("crossed 128 words");

  property p_latency;
    @(posedge burst_clk_in) disable iff (reset_in)
    $rose(valid_ff) && $past(st_ff) == ST_WAIT |-> since_cap_ff == 5'(lat_cycles);
  endproperty
  a_latency: assert property (p_latency) else $error("initial latency wrong");

  property p_ready_early;
    @(posedge burst_clk_in) disable iff (reset_in)
    lcfg_ff[CFG_RDY_EARLY_BIT] && ready_out == lcfg_ff[CFG_RDY_POL_BIT] && $stable(lcfg_ff)
      |=> valid_ff;
  endproperty
  a_ready_early: assert property (p_ready_early) else $error("early ready without data");

  property p_write_async;
    @(posedge burst_clk_in) disable iff (reset_in)
    !write_enable_n_in |=> st_ff == ST_IDLE && adq_oe_n_out;
  endproperty
  a_write_async: assert property (p_write_async) else $error("burst during write");

  property p_cmd_reset;
    @(posedge clock_in) disable iff (reset_in)
    cmd_reset_in && !cfg_write_in |=> $stable(cfg_rdata_out);
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("command reset hit config");

  property p_cfg_default;
    @(posedge clock_in) disable iff (reset_in)
    $past(reset_in) && !$past(cfg_write_in) |-> cfg_rdata_out == CFG_DEFAULT;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not default");

  c_hold8: cover property (@(posedge burst_clk_in) disable iff (reset_in)
    wrap8 && st_ff == ST_HOLD);
  c_stall16: cover property (@(posedge burst_clk_in) disable iff (reset_in)
    st_ff == ST_STALL);
  c_cont_wrap: cover property (@(posedge burst_clk_in) disable iff (reset_in)
    valid_ff && !wrap8 && !wrap16 && addr_ff == '0);
endmodule // brw_burst

// ---- logic/brw_pkg.sv ----
/*
  Constants, types and register layout for the burst read wrap engine.
  Assumes one core clock of 200 MHz and a burst clock supplied by the host.
*/
// Summary of operation
// - Wrap group is the aligned 16-byte or 32-byte group holding the start address.
// - Wrap burst starts at given word, steps up, wraps to group start, bounded count.
// - Eight-word wrap words come on consecutive clocks after the initial latency.
// - Last word of eight-word wrap stays driven until chip select, new address or reset.
// - Sixteen-word wrap may add wait states at the first half crossing.
// - Wrap bursts never cross a 128-word boundary, so no crossing waits.
// - Power-up or hardware reset gives idle state and default configuration.
// - Host can read back the configuration register contents.
// - Command reset leaves the configuration register unchanged.
// - Bit 15 zero selects synchronous burst reads, one asynchronous; one by default.
// - Writes always use asynchronous timing regardless of read mode.
// - Bits 14..11 code 0001 gives data on third clock; each code adds one; 1011 default.
// - After wait states each rising edge presents the next word and advances address.
// - Bit 10 sets ready polarity: zero active low, one active high (default).
// - Bits 2..0: continuous default, 010 eight-word wrap, 011 sixteen-word wrap.
// - Continuous burst counts up, wraps top to zero until aborted.
// - Bit 8 zero: ready with data; bit 8 one: ready one cycle earlier.
package brw_pkg;

  // ******************************************************************
  // Widths.
  // ******************************************************************
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned HI_W   = 8;

  // ******************************************************************
  // Configuration register layout and reset value.
  // ******************************************************************
  localparam int unsigned CFG_READ_MODE_BIT = 15;
  localparam int unsigned CFG_LAT_MSB       = 14;
  localparam int unsigned CFG_LAT_LSB       = 11;
  localparam int unsigned CFG_RDY_POL_BIT   = 10;
  localparam int unsigned CFG_RDY_EARLY_BIT = 8;
  localparam int unsigned CFG_LEN_MSB       = 2;
  localparam int unsigned CFG_LEN_LSB       = 0;
  localparam logic [15:0] CFG_DEFAULT       = 16'hdf48;

  // Burst length codes.
  localparam logic [2:0] LEN_CONT  = 3'h0;
  localparam logic [2:0] LEN_WRAP8 = 3'h2;
  localparam logic [2:0] LEN_WRAP16 = 3'h3;

  // ******************************************************************
  // Latency codes and cycle counts.
  // ******************************************************************
  localparam logic [3:0] LAT_CODE_MIN = 4'h1;
  localparam logic [3:0] LAT_CODE_MAX = 4'hb;
  localparam logic [3:0] LAT_OFFSET   = 4'h2;
  localparam logic [3:0] LAT_MIN      = 4'h3;
  localparam logic [3:0] LAT_MAX      = 4'hd;
  localparam logic [3:0] HALF_WS_BASE = 4'h8;
  localparam logic [4:0] WORDS_WRAP8  = 5'h08;
  localparam logic [4:0] WORDS_WRAP16 = 5'h10;

  // Burst engine states.
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_BURST = 5'b00100,
    ST_STALL = 5'b01000,
    ST_HOLD  = 5'b10000
  } brw_state_t;

endpackage : brw_pkg

// ---- logic/brw_sync.sv ----
/*
  Two flip-flop level synchroniser.
  Assumes the input is a level that stays put for several destination clocks.
*/
`timescale 1ns/10ps
module brw_sync (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic level_in,
  output logic      level_out
);
  logic meta_ff;

  // ******************************************************************
  // The first stage feeds only the second stage.
  // ******************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_ff   <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_ff   <= level_in;
      level_out <= meta_ff;
    end
  end
endmodule // brw_sync

// ---- tb/brw_host.sv ----
/*
  Host-side model of the burst link: makes the link clock, strobes addresses, records outputs.
  Assumes the bench calls its tasks one at a time from a single process.
*/
`timescale 1ns/10ps
module brw_host (
  input  wire logic        ready_in,
  input  wire logic        oe_n_in,
  input  wire logic [15:0] data_in,
  output logic             burst_clk_out,
  output logic             cs_n_out,
  output logic             strobe_n_out,
  output logic             we_n_out,
  output logic [7:0]       addr_hi_out,
  output logic [15:0]      adq_out
);
  logic        q_rdy [$];
  logic        q_oe  [$];
  logic [15:0] q_dat [$];

  // Idle levels: deselected, no strobe, no write.
  initial begin
    burst_clk_out = 1'b0;
    cs_n_out      = 1'b1;
    strobe_n_out  = 1'b1;
    we_n_out      = 1'b1;
    addr_hi_out   = 8'h00;
    adq_out       = 16'h0000;
  end

  // One 64 ns link clock; outputs are sampled and inputs changed after the falling edge.
  task automatic tick();
    #32 burst_clk_out = 1'b1;
    #32 burst_clk_out = 1'b0;
    q_rdy.push_back(ready_in);
    q_oe.push_back(oe_n_in);
    q_dat.push_back(data_in);
    if (strobe_n_out) adq_out = ~adq_out; // Released lines toggle so stale values never match.
  endtask

  // Clocks with the chip deselected, giving a new configuration time to cross.
  task automatic idle(input int n);
    cs_n_out     = 1'b1;
    strobe_n_out = 1'b1;
    repeat (n) tick();
  endtask

  // Latches a start address; the bench configures the device beforehand, except before the first burst, which runs on the reset default.
  task automatic start(input logic [23:0] a, input logic we_n);
    cs_n_out               = 1'b0;
    strobe_n_out           = 1'b0;
    we_n_out               = we_n; // Low only to mark an asynchronous write cycle.
    {addr_hi_out, adq_out} = a;
    tick();
    strobe_n_out = 1'b1;
    we_n_out     = 1'b1;
    adq_out      = ~adq_out;
    q_rdy.delete();
    q_oe.delete();
    q_dat.delete();
  endtask
endmodule // brw_host

// ---- tb/burst_read_wrap_config_tb.sv ----
/*
  Self-checking bench for the burst read wrap engine, with a queue model of each burst.
  Assumes the host model in brw_host.sv and an array answering from the word address.
*/
`timescale 1ns/10ps
module burst_read_wrap_config_tb;
  import brw_pkg::*;
  logic        clock_in, reset_in, cfg_write_in, cmd_reset_in;
  logic [15:0] cfg_wdata_in, cfg_rdata_out, adq_in, adq_out, mem_data_in, cfg_now, v;
  logic        burst_clk_in, chip_select_n_in, address_valid_strobe_n_in, write_enable_n_in;
  logic        adq_oe_n_out, ready_out;
  logic [7:0]  addr_hi_in;
  logic [23:0] mem_addr_out;
  logic [2:0]  lens [3] = '{LEN_CONT, LEN_WRAP8, LEN_WRAP16};
  int          num_errors, samples_checked, t;

  // ************************************************************
  // Clock, array and instances.
  // ************************************************************
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  function automatic logic [15:0] word_at(input logic [23:0] p);
    return p[15:0] ^ {p[23:16], 8'h5a};
  endfunction

  // The array answers at once for the address that the engine presents.
  assign mem_data_in = word_at(mem_addr_out);

  brw_burst DUT (.clock_in(clock_in), .reset_in(reset_in), .cfg_write_in(cfg_write_in),
    .cfg_wdata_in(cfg_wdata_in), .cmd_reset_in(cmd_reset_in), .cfg_rdata_out(cfg_rdata_out),
    .burst_clk_in(burst_clk_in), .chip_select_n_in(chip_select_n_in),
    .address_valid_strobe_n_in(address_valid_strobe_n_in),
    .write_enable_n_in(write_enable_n_in), .addr_hi_in(addr_hi_in), .adq_in(adq_in),
    .adq_out(adq_out), .adq_oe_n_out(adq_oe_n_out), .ready_out(ready_out),
    .mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in));

  brw_host host (.ready_in(ready_out), .oe_n_in(adq_oe_n_out), .data_in(adq_out),
    .burst_clk_out(burst_clk_in), .cs_n_out(chip_select_n_in),
    .strobe_n_out(address_valid_strobe_n_in), .we_n_out(write_enable_n_in),
    .addr_hi_out(addr_hi_in), .adq_out(adq_in));

  // ************************************************************
  // Checking and bus tasks.
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hardware reset held across both clocks, then the defaults are checked.
  task automatic hw_reset();
    @(negedge clock_in);
    reset_in = 1'b1;
    fork
      host.idle(4);
      repeat (5) @(negedge clock_in);
    join
    @(negedge clock_in);
    reset_in = 1'b0;
    check(cfg_rdata_out & 16'hfd07, 16'hdd00, "reset config");
    check(16'(adq_oe_n_out), 16'h0001, "idle drive");
    check(16'(ready_out), 16'h0000, "idle ready");
    cfg_now = 16'hdd00;
  endtask

  // Writes the configuration, reads it back and lets it cross to the link.
  task automatic set_cfg(input logic [15:0] val);
    @(negedge clock_in);
    cfg_write_in = 1'b1;
    cfg_wdata_in = val;
    @(negedge clock_in);
    cfg_write_in = 1'b0;
    check(cfg_rdata_out, val, "config readback");
    cfg_now = val;
    host.idle(4);
  endtask

  // Runs one burst of len edges and compares every edge with the queue model.
  task automatic burst(input logic [23:0] a, input int len, input logic we_n);
    int          lat, maxw, stall, words, i, k;
    bit          sync, crossed, on, act;
    bit          valid [$];
    logic [15:0] dat [$];
    logic [15:0] last;
    logic [23:0] p;
    lat   = int'(cfg_now[14:11]) + 2;
    maxw  = cfg_now[2:0] === LEN_WRAP8 ? 8 : cfg_now[2:0] === LEN_WRAP16 ? 16 : 1 << 30;
    stall = int'(a[2:0]) + (lat < 8 ? lat : 8) - 8;
    sync  = !cfg_now[15] && we_n;
    p     = a;
    words = 0;
    crossed = 1'b0;
    i     = lat;
    last  = 16'h0000;
    for (k = 0; k <= len + 1; k++) begin
      valid.push_back(1'b0);
      dat.push_back(16'h0000);
    end
    while (sync && i <= len + 1 && words < maxw) begin
      if (maxw == 16 && !crossed && p[3] != a[3]) begin
        crossed = 1'b1;
        i += stall > 0 ? stall : 0;
      end else begin
        valid[i] = 1'b1;
        dat[i] = word_at(p);
        words++;
        i++;
        p = maxw == 8 ? {p[23:3], p[2:0] + 3'h1} : maxw == 16 ? {p[23:4], p[3:0] + 4'h1} :
          p + 24'h000001;
      end
    end
    host.start(a, we_n);
    repeat (len) host.tick();
    for (k = 1; k <= len; k++) begin
      if (valid[k]) last = dat[k];
      on  = sync && k >= lat;
      act = cfg_now[8] ? valid[k + 1] : valid[k];
      check(16'(host.q_oe[k - 1]), 16'(!on), "drive enable");
      check(16'(host.q_rdy[k - 1]), 16'(cfg_now[10] ? act : !act), "ready");
      if (on) check(host.q_dat[k - 1], last, "word");
    end
  endtask

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    num_errors      = 0;
    samples_checked = 0;
    reset_in        = 1'b1;
    cfg_write_in    = 1'b0;
    cmd_reset_in    = 1'b0;
    cfg_wdata_in    = 16'h0000;
    void'($urandom(32'h73dec355));
    hw_reset();
    burst(24'h000123, 16, 1'b1);
    $display("reset and asynchronous default done");
    set_cfg(16'h0e4a);
    @(negedge clock_in);
    cmd_reset_in = 1'b1;
    @(negedge clock_in);
    cmd_reset_in = 1'b0;
    @(negedge clock_in);
    check(cfg_rdata_out, 16'h0e4a, "after command reset");
    $display("command reset done");
    burst(24'h00001e, 14, 1'b1);
    burst(24'h000035, 14, 1'b1);
    host.idle(1);
    check(16'(adq_oe_n_out), 16'h0001, "deselect");
    burst(24'h000040, 8, 1'b0);
    $display("eight-word wrap and aborts done");
    set_cfg(16'h0b48);
    burst(24'hfffffd, 12, 1'b1);
    $display("continuous top wrap done");
    for (t = 0; t < 12; t++) begin
      v = {1'b0, 4'(1 + $urandom % 11), 1'($urandom), 1'b1, 1'($urandom), 5'h09, lens[t % 3]};
      set_cfg(v);
      burst(24'($urandom), 36, 1'b1);
    end
    $display("random bursts done");
    set_cfg(16'h0e4b);
    host.start(24'h000047, 1'b1);
    repeat (6) host.tick();
    hw_reset();
    $display("mid-burst reset done");
    conclude();
  end

  // Watchdog in case a task never returns.
  initial begin
    #400000;
    num_errors++;
    $display("[ERR] %0t run did not finish", $time);
    conclude();
  end
endmodule // burst_read_wrap_config_tb
